/* hdl/dsz_top.sv */
/*
  Direction select and zero speed detect with an AHB-Lite register slave.
  Assumes a single 100 MHz clock, a one-cycle millisecond tick from the
  device timebase, and inputs synchronous to hclk.
*/
// Our own choices: the AHB-Lite register port and the address map.
`timescale 1ns/10ps
`include "dsz_consts.svh"

module dsz_top #(
  parameter int VEL_W = 16
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic ms_tick,
  input wire logic signed [VEL_W-1:0] actual_speed,
  input wire logic direction_reverse_input,
  output logic [VEL_W-1:0] speed_magnitude,
  output logic dir_ccw,
  output logic zero_speed_pin,
  output logic irq
);
  import dsz_pkg::*;

  // ****************************************************************
  // Register state
  // ****************************************************************
  logic direction_polarity_setting_q;
  logic [7:0] in_func_q;
  logic [7:0] out_func_q;
  logic [14:0] motion_condition_time_q;
  logic [VEL_W-1:0] zero_speed_threshold_q;
  logic signed [VEL_W-1:0] vel_cmd_q;
  logic [2:0] int_stat_q;
  logic [2:0] int_mask_q;
  dsz_bus_state_type bus_q;
  logic wr_pend_q;
  logic [7:0] addr_q;
  logic hreadyout_q;
  logic [31:0] hrdata_q;
  logic irq_q;

  // ****************************************************************
  // Bus decode
  // ****************************************************************
  logic take;
  logic wr_now;
  logic [31:0] rd_mux;
  logic [2:0] w1c;

  assign take = hsel & htrans[1] & hready;
  assign wr_now = wr_pend_q;
  assign hreadyout = hreadyout_q;
  assign hresp = 1'b0;
  assign hrdata = hrdata_q;
  assign irq = irq_q;

  // Reads take one wait state so that a write just before is visible
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bus_q <= DSZ_BUS_IDLE;
      wr_pend_q <= 1'b0;
      addr_q <= 8'h00;
      hreadyout_q <= 1'b1;
      hrdata_q <= 32'h0000_0000;
    end else begin
      case (bus_q)
        DSZ_BUS_IDLE: begin
          wr_pend_q <= take & hwrite;
          if (take) begin
            addr_q <= haddr[7:0];
          end
          if (take & ~hwrite) begin
            bus_q <= DSZ_BUS_RDWAIT;
            hreadyout_q <= 1'b0;
          end
        end
        DSZ_BUS_RDWAIT: begin
          hrdata_q <= rd_mux;
          hreadyout_q <= 1'b1;
          bus_q <= DSZ_BUS_IDLE;
        end
        default: begin
          bus_q <= DSZ_BUS_IDLE;
        end
      endcase
    end
  end

  // ****************************************************************
  // Direction logic
  // ****************************************************************
  logic rev_active;
  logic cmd_neg;
  logic [VEL_W-1:0] cmd_mag;
  dsz_status_type status;

  always_comb begin
    if (in_func_q == `DSZ_IN_REV_CLOSED) begin
      rev_active = direction_reverse_input;
    end else if (in_func_q == `DSZ_IN_REV_OPEN) begin
      rev_active = ~direction_reverse_input;
    end else begin
      rev_active = 1'b0;
    end
  end

  assign cmd_neg = vel_cmd_q[VEL_W-1];
  assign cmd_mag = cmd_neg ? VEL_W'(-vel_cmd_q) : VEL_W'(vel_cmd_q);

  // ****************************************************************
  // Zero speed detect
  // ****************************************************************
  logic [VEL_W-1:0] abs_speed;
  logic below;
  logic above;
  logic [14:0] qual_cnt_q;
  logic zero_flag_q;
  logic dir_ccw_q;
  logic zero_speed_pin_q;
  logic [VEL_W-1:0] speed_magnitude_q;

  assign abs_speed = actual_speed[VEL_W-1] ? VEL_W'(-actual_speed) : VEL_W'(actual_speed);
  assign below = abs_speed < zero_speed_threshold_q;
  assign above = abs_speed > zero_speed_threshold_q;

  // No gating by mode or enable: detection runs every cycle
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      qual_cnt_q <= 15'h0000;
    end else if (!below) begin
      qual_cnt_q <= 15'h0000;
    end else if (ms_tick && qual_cnt_q != `DSZ_QUAL_MAX) begin
      qual_cnt_q <= qual_cnt_q + 15'h0001;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      zero_flag_q <= 1'b0;
    end else if (above) begin
      zero_flag_q <= 1'b0;
    end else if (below && qual_cnt_q >= motion_condition_time_q) begin
      zero_flag_q <= 1'b1;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dir_ccw_q <= 1'b0;
      speed_magnitude_q <= '0;
    end else begin
      dir_ccw_q <= direction_polarity_setting_q ^ cmd_neg ^ rev_active;
      speed_magnitude_q <= cmd_mag;
    end
  end

  // Unassigned output stays open: pin level 0 means open contact
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      zero_speed_pin_q <= 1'b0;
    end else if (out_func_q == `DSZ_OUT_ZS_CLOSED) begin
      zero_speed_pin_q <= zero_flag_q;
    end else if (out_func_q == `DSZ_OUT_ZS_OPEN) begin
      zero_speed_pin_q <= ~zero_flag_q;
    end else begin
      zero_speed_pin_q <= 1'b0;
    end
  end

  assign dir_ccw = dir_ccw_q;
  assign speed_magnitude = speed_magnitude_q;
  assign zero_speed_pin = zero_speed_pin_q;
  assign status = '{rev_active: rev_active, dir_ccw: dir_ccw_q, zero_flag: zero_flag_q};

  // ****************************************************************
  // Configuration registers
  // ****************************************************************
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      direction_polarity_setting_q <= 1'b0;
      in_func_q <= `DSZ_IN_GENERAL_PURPOSE;
      out_func_q <= 8'h00;
      motion_condition_time_q <= `DSZ_QUAL_RST;
      zero_speed_threshold_q <= VEL_W'(`DSZ_THR_RST);
      vel_cmd_q <= '0;
      int_mask_q <= 3'h0;
    end else if (wr_now) begin
      if (addr_q == `DSZ_OFS_DIR_CFG) begin
        direction_polarity_setting_q <= hwdata[0];
        in_func_q <= hwdata[15:8];
      end else if (addr_q == `DSZ_OFS_ZS_CFG) begin
        out_func_q <= hwdata[7:0];
      end else if (addr_q == `DSZ_OFS_QUAL_TIME) begin
        // Values beyond the range are clamped, not wrapped
        motion_condition_time_q <= (hwdata[31:0] > 32'(`DSZ_QUAL_MAX)) ?
          `DSZ_QUAL_MAX : hwdata[14:0];
      end else if (addr_q == `DSZ_OFS_THRESH) begin
        if (hwdata[31:0] < 32'(`DSZ_THR_MIN)) begin
          zero_speed_threshold_q <= VEL_W'(`DSZ_THR_MIN);
        end else if (hwdata[31:0] > 32'(`DSZ_THR_MAX)) begin
          zero_speed_threshold_q <= VEL_W'(`DSZ_THR_MAX);
        end else begin
          zero_speed_threshold_q <= hwdata[VEL_W-1:0];
        end
      end else if (addr_q == `DSZ_OFS_VEL_CMD) begin
        vel_cmd_q <= hwdata[VEL_W-1:0];
      end else if (addr_q == `DSZ_OFS_INT_MASK) begin
        int_mask_q <= hwdata[2:0];
      end
    end
  end

  // ****************************************************************
  // Interrupts
  // ****************************************************************
  logic zero_flag_d1_q;
  logic dir_d1_q;
  logic [2:0] ev;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      zero_flag_d1_q <= 1'b0;
      dir_d1_q <= 1'b0;
    end else begin
      zero_flag_d1_q <= zero_flag_q;
      dir_d1_q <= dir_ccw_q;
    end
  end

  always_comb begin
    ev = 3'h0;
    ev[`DSZ_EV_ZS_SET] = zero_flag_q & ~zero_flag_d1_q;
    ev[`DSZ_EV_ZS_CLR] = ~zero_flag_q & zero_flag_d1_q;
    ev[`DSZ_EV_DIR] = dir_ccw_q ^ dir_d1_q;
  end

  assign w1c = (wr_now && addr_q == `DSZ_OFS_INT_STAT) ? hwdata[2:0] : 3'h0;

  // A new event outranks a clear in the same cycle
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      int_stat_q <= 3'h0;
      irq_q <= 1'b0;
    end else begin
      int_stat_q <= (int_stat_q & ~w1c) | ev;
      irq_q <= |(((int_stat_q & ~w1c) | ev) & int_mask_q);
    end
  end

  // ****************************************************************
  // Read mux
  // ****************************************************************
  always_comb begin
    rd_mux = 32'h0000_0000;
    if (addr_q == `DSZ_OFS_DIR_CFG) begin
      rd_mux = {16'h0000, in_func_q, 7'h00, direction_polarity_setting_q};
    end else if (addr_q == `DSZ_OFS_ZS_CFG) begin
      rd_mux = {24'h00_0000, out_func_q};
    end else if (addr_q == `DSZ_OFS_QUAL_TIME) begin
      rd_mux = {17'h0_0000, motion_condition_time_q};
    end else if (addr_q == `DSZ_OFS_THRESH) begin
      rd_mux = 32'(zero_speed_threshold_q);
    end else if (addr_q == `DSZ_OFS_VEL_CMD) begin
      rd_mux = 32'(unsigned'(vel_cmd_q));
    end else if (addr_q == `DSZ_OFS_STATUS) begin
      rd_mux = {29'h0000_0000, status};
    end else if (addr_q == `DSZ_OFS_INT_STAT) begin
      rd_mux = {29'h0000_0000, int_stat_q};
    end else if (addr_q == `DSZ_OFS_INT_MASK) begin
      rd_mux = {29'h0000_0000, int_mask_q};
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  dir_combine_a: assert property (@(posedge hclk) disable iff (!hresetn)
    dir_ccw_q == $past(direction_polarity_setting_q ^ cmd_neg ^ rev_active))
    else $error("direction does not match polarity, sign and reverse");

  sign_only_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (in_func_q == `DSZ_IN_GENERAL_PURPOSE) |=>
      (dir_ccw_q == $past(direction_polarity_setting_q ^ cmd_neg)))
    else $error("direction not set by polarity and command sign alone");

  rev_closed_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (in_func_q == `DSZ_IN_REV_CLOSED) |=>
      (dir_ccw_q == $past(direction_polarity_setting_q ^ cmd_neg ^ direction_reverse_input)))
    else $error("closed-active reverse input misread");

  rev_open_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (in_func_q == `DSZ_IN_REV_OPEN) |=>
      (dir_ccw_q == $past(direction_polarity_setting_q ^ cmd_neg ^ !direction_reverse_input)))
    else $error("open-active reverse input misread");

  flag_clear_a: assert property (@(posedge hclk) disable iff (!hresetn)
    above |=> !zero_flag_q)
    else $error("zero speed flag held above threshold");

  flag_qualify_a: assert property (@(posedge hclk) disable iff (!hresetn)
    $rose(zero_flag_q) |-> $past(below) && $past(qual_cnt_q) >= $past(motion_condition_time_q))
    else $error("zero speed flag set before qualify time");

  count_restart_a: assert property (@(posedge hclk) disable iff (!hresetn)
    !below |=> (qual_cnt_q == 15'h0000))
    else $error("qualify counter not restarted");

  pin_polarity_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (out_func_q == `DSZ_OUT_ZS_OPEN) && $stable(out_func_q) |=>
      (zero_speed_pin_q == !$past(zero_flag_q)))
    else $error("open-active zero speed pin misdriven");

  thr_range_a: assert property (@(posedge hclk) disable iff (!hresetn)
    zero_speed_threshold_q >= `DSZ_THR_MIN && zero_speed_threshold_q <= `DSZ_THR_MAX)
    else $error("threshold out of range");

  magnitude_a: assert property (@(posedge hclk) disable iff (!hresetn)
    ##1 speed_magnitude_q == $past(cmd_mag))
    else $error("speed magnitude does not follow command");

endmodule

/* hdl/dsz_consts.svh */
/*
  Offsets, field positions, reset values and codes of the direction select
  and zero speed detect block. Assumes inclusion by bare name only.
*/
`ifndef DSZ_CONSTS_SVH
`define DSZ_CONSTS_SVH

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define DSZ_OFS_DIR_CFG 8'h00
`define DSZ_OFS_ZS_CFG 8'h04
`define DSZ_OFS_QUAL_TIME 8'h08
`define DSZ_OFS_THRESH 8'h0C
`define DSZ_OFS_VEL_CMD 8'h10
`define DSZ_OFS_STATUS 8'h14
`define DSZ_OFS_INT_STAT 8'h18
`define DSZ_OFS_INT_MASK 8'h1C

// ****************************************************************
// Function codes and limits
// ****************************************************************
`define DSZ_IN_GENERAL_PURPOSE 8'h00
`define DSZ_IN_REV_CLOSED 8'h23
`define DSZ_IN_REV_OPEN 8'h24
`define DSZ_OUT_ZS_CLOSED 8'h21
`define DSZ_OUT_ZS_OPEN 8'h22
`define DSZ_QUAL_MAX 15'h7530
`define DSZ_QUAL_RST 15'h000A
`define DSZ_THR_MIN 16'h0001
`define DSZ_THR_MAX 16'h0014
`define DSZ_THR_RST 16'h0005

// ****************************************************************
// Interrupt bit positions
// ****************************************************************
`define DSZ_EV_ZS_SET 0
`define DSZ_EV_ZS_CLR 1
`define DSZ_EV_DIR 2

`endif

/* hdl/dsz_pkg.sv */
/*
  Types of the direction select and zero speed detect block.
  Assumes nothing of its surroundings.
*/
package dsz_pkg;

  typedef enum logic [0:0] {
    DSZ_BUS_IDLE = 1'b0,
    DSZ_BUS_RDWAIT = 1'b1
  } dsz_bus_state_type;

  typedef struct packed {
    logic rev_active;
    logic dir_ccw;
    logic zero_flag;
  } dsz_status_type;

endpackage

/* tb/dsz_switch_model.sv */
/*
  Far side of the block: the reverse switch contact, the motor speed source
  and the equipment watching the zero speed output contact.
  Assumes the bench sets contact state and speed just after a clock edge.
*/
`timescale 1ns/10ps
module dsz_switch_model (
  input wire logic contact_closed,
  input wire logic signed [15:0] speed_set,
  input wire logic zero_speed_pin,
  output logic direction_reverse_input,
  output logic signed [15:0] actual_speed,
  output logic pin_closed
);
  import dsz_pkg::*;
  // A closed contact reads as 1 at the drive input
  assign direction_reverse_input = contact_closed;
  assign actual_speed = speed_set;
  // The monitor sees the contact closed while the pin is driven high
  assign pin_closed = zero_speed_pin;
endmodule

/* tb/tb_direction_select_zero_speed_detect.sv */
/*
  Self-checking bench for the direction select and zero speed block.
  Assumes one 100 MHz clock and a shortened millisecond tick.
*/
`timescale 1ns/10ps
`include "dsz_consts.svh"
module tb_direction_select_zero_speed_detect;
  import dsz_pkg::*;
  typedef struct packed {
    logic pol;
    logic [7:0] code;
    logic [15:0] cmd;
    logic closed;
    logic ccw;
  } dsz_dir_row_type;
  typedef struct packed {
    logic [7:0] ofs;
    logic [31:0] wr;
    logic [31:0] rd;
  } dsz_reg_row_type;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic ms_tick = 1'b0;
  logic contact_closed = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic signed [15:0] speed_set = 16'sh001E;
  logic [31:0] hrdata;
  logic [31:0] rd;
  logic hreadyout;
  logic hresp;
  logic dir_ccw;
  logic zero_speed_pin;
  logic irq;
  logic direction_reverse_input;
  logic pin_closed;
  logic signed [15:0] actual_speed;
  logic [15:0] speed_magnitude;
  int fail_count = 0;
  int n_tests = 0;
  dsz_reg_row_type reg_rows[6] = '{
    '{`DSZ_OFS_QUAL_TIME, 32'h00009C40, 32'h00007530},
    '{`DSZ_OFS_THRESH, 32'h00000000, 32'h00000001},
    '{`DSZ_OFS_THRESH, 32'h00000064, 32'h00000014},
    '{`DSZ_OFS_THRESH, 32'h00000005, 32'h00000005},
    '{`DSZ_OFS_QUAL_TIME, 32'h00000004, 32'h00000004},
    '{8'h40, 32'hFFFFFFFF, 32'h00000000}};
  dsz_dir_row_type dir_rows[11] = '{
    '{1'b0, `DSZ_IN_GENERAL_PURPOSE, 16'h0014, 1'b0, 1'b0},
    '{1'b0, `DSZ_IN_GENERAL_PURPOSE, 16'hFFEC, 1'b0, 1'b1},
    '{1'b1, `DSZ_IN_GENERAL_PURPOSE, 16'h0014, 1'b0, 1'b1},
    '{1'b1, `DSZ_IN_GENERAL_PURPOSE, 16'hFFEC, 1'b1, 1'b0},
    '{1'b0, `DSZ_IN_REV_CLOSED, 16'h0014, 1'b1, 1'b1},
    '{1'b0, `DSZ_IN_REV_CLOSED, 16'h0014, 1'b0, 1'b0},
    '{1'b1, `DSZ_IN_REV_CLOSED, 16'hFFEC, 1'b1, 1'b1},
    '{1'b0, `DSZ_IN_REV_OPEN, 16'h0014, 1'b0, 1'b1},
    '{1'b0, `DSZ_IN_REV_OPEN, 16'hFFEC, 1'b1, 1'b1},
    '{1'b1, `DSZ_IN_REV_OPEN, 16'h0014, 1'b1, 1'b1},
    '{1'b1, `DSZ_IN_REV_OPEN, 16'h0014, 1'b0, 1'b0}};

  always #5 hclk = ~hclk;

  dsz_top i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .ms_tick(ms_tick), .actual_speed(actual_speed),
    .direction_reverse_input(direction_reverse_input),
    .speed_magnitude(speed_magnitude), .dir_ccw(dir_ccw),
    .zero_speed_pin(zero_speed_pin), .irq(irq));

  dsz_switch_model i_switch (.contact_closed(contact_closed), .speed_set(speed_set),
    .zero_speed_pin(zero_speed_pin), .direction_reverse_input(direction_reverse_input),
    .actual_speed(actual_speed), .pin_closed(pin_closed));

  // ****************************************************************
  // Bus cycles and comparison
  // ****************************************************************
  task automatic ahb_xfer(input logic wr, input logic [7:0] ofs, input logic [31:0] wd);
    hsel <= 1'b1;
    haddr <= {24'h0, ofs};
    htrans <= 2'h2;
    hwrite <= wr;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Each tick is followed by three edges so the flag and pin can settle
  task automatic tick(input int n);
    repeat (n) begin
      ms_tick <= 1'b1;
      @(posedge hclk);
      ms_tick <= 1'b0;
      repeat (3) @(posedge hclk);
    end
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    repeat (16) @(posedge hclk);
    check({hreadyout, hresp, dir_ccw, pin_closed, irq}, 32'h10);
    hresetn <= 1'b1;
    @(posedge hclk);
    ahb_xfer(1'b0, `DSZ_OFS_QUAL_TIME, 32'h0);
    check(rd, 32'h0000000A);
    ahb_xfer(1'b0, `DSZ_OFS_THRESH, 32'h0);
    check(rd, 32'h00000005);
    foreach (reg_rows[i]) begin
      ahb_xfer(1'b1, reg_rows[i].ofs, reg_rows[i].wr);
      ahb_xfer(1'b0, reg_rows[i].ofs, 32'h0);
      check(rd, reg_rows[i].rd);
    end
    foreach (dir_rows[i]) begin
      contact_closed <= dir_rows[i].closed;
      ahb_xfer(1'b1, `DSZ_OFS_DIR_CFG, {16'h0, dir_rows[i].code, 7'h0, dir_rows[i].pol});
      ahb_xfer(1'b1, `DSZ_OFS_VEL_CMD, {16'h0, dir_rows[i].cmd});
      repeat (3) @(posedge hclk);
      check(dir_ccw, dir_rows[i].ccw);
      check(speed_magnitude, 16'h0014);
    end
    // Zero speed output needs its function assigned first
    ahb_xfer(1'b1, `DSZ_OFS_ZS_CFG, 32'(`DSZ_OUT_ZS_CLOSED));
    repeat (4) @(posedge hclk);
    check(pin_closed, 1'b0);
    speed_set <= 16'shFFFD;
    tick(3);
    check(pin_closed, 1'b0);
    speed_set <= 16'sh0006;
    repeat (2) @(posedge hclk);
    speed_set <= 16'shFFFD;
    tick(3);
    check(pin_closed, 1'b0);
    tick(1);
    check(pin_closed, 1'b1);
    ahb_xfer(1'b0, `DSZ_OFS_STATUS, 32'h0);
    check(rd[0], 1'b1);
    check(irq, 1'b0);
    ahb_xfer(1'b1, `DSZ_OFS_INT_MASK, 32'h1);
    repeat (3) @(posedge hclk);
    check(irq, 1'b1);
    ahb_xfer(1'b1, `DSZ_OFS_INT_STAT, 32'h1);
    repeat (3) @(posedge hclk);
    check(irq, 1'b0);
    ahb_xfer(1'b0, `DSZ_OFS_INT_STAT, 32'h0);
    check(rd[0], 1'b0);
    ahb_xfer(1'b1, `DSZ_OFS_ZS_CFG, 32'(`DSZ_OUT_ZS_OPEN));
    repeat (3) @(posedge hclk);
    check(pin_closed, 1'b0);
    speed_set <= 16'shFFE2;
    repeat (4) @(posedge hclk);
    check(pin_closed, 1'b1);
    // Flag fell and direction changed are still pending; rose was cleared
    ahb_xfer(1'b0, `DSZ_OFS_INT_STAT, 32'h0);
    check(rd, 32'h00000006);
    ahb_xfer(1'b1, `DSZ_OFS_INT_MASK, 32'h2);
    repeat (3) @(posedge hclk);
    check(irq, 1'b1);
    // Mid-run reset must drop every output but hreadyout, which goes high, and restore the defaults
    hresetn <= 1'b0;
    @(posedge hclk);
    check({hreadyout, hresp, dir_ccw, pin_closed, irq}, 32'h10);
    check(speed_magnitude, 16'h0000);
    hresetn <= 1'b1;
    @(posedge hclk);
    ahb_xfer(1'b0, `DSZ_OFS_QUAL_TIME, 32'h0);
    check(rd, 32'h0000000A);
    ahb_xfer(1'b0, `DSZ_OFS_INT_STAT, 32'h0);
    check(rd, 32'h00000000);
    check(hresp, 1'b0);
    report_and_stop();
  end

  // Whole run takes a few hundred cycles; this leaves wide margin
  initial begin
    #500000;
    fail_count++;
    report_and_stop();
  end
endmodule
